// file: hw/branch_skip_bit_unit.sv
// Execution unit for calls, returns, compares, skips, branches, I/O bits and shifts
`timescale 1ns/1ps
`include "flow_unit_defs.svh"

module branch_skip_bit_unit
	import flow_unit_pkg::*;
(
	input  wire logic        clk,          // Core clock, 100 MHz
	input  wire logic        srst,         // Synchronous reset, active high
	input  wire logic        start,        // Instruction offered this cycle
	input  wire instr_t      instr,        // Decoded instruction and operands
	input  wire logic [7:0]  status_flags_register_in,      // Current status flags
	input  wire logic [15:0] pop_data,     // Stack word, valid after pop
	output logic             busy_q,       // Multi-cycle instruction running
	output logic             done_q,       // Instruction finished, pulse
	output logic             pc_load_q,    // Load pc_next_q into PC, pulse
	output logic [15:0]      pc_next_q,    // New program counter
	output logic             status_flags_register_we_q,    // Write status_flags_register_out_q, pulse
	output logic [7:0]       status_flags_register_out_q,   // New status flags
	output logic             res_we_q,     // Write res_q to destination, pulse
	output logic [7:0]       res_q,        // Shift result
	output logic             io_we_q,      // Masked I/O write, pulse
	output logic [5:0]       io_addr_q,    // I/O register address
	output logic [7:0]       io_mask_q,    // Bits to change
	output logic [7:0]       io_wdata_q,   // New value of the masked bits
	output logic             push_q,       // Push push_data_q, pulse
	output logic [15:0]      push_data_q,  // Return address
	output logic             pop_q,        // Pop request, pulse
	output logic             bad_io_q      // I/O bit op outside range, pulse
);

	// ********************
	// Decode and evaluate
	// ********************
	state_t      state_q;
	logic [2:0]  cnt_q;
	logic        pend_pc_q;
	logic        pend_ret_q;
	logic        pend_io_q;
	logic        pend_irq_q;
	logic        accept;
	logic        cond;
	logic        is_skip;
	logic        is_branch;
	logic        io_ok;
	logic        sel_bit;
	logic [8:0]  diff;
	logic [7:0]  shres;
	logic        sh_c;
	logic [7:0]  cmp_flags;
	logic [7:0]  sh_flags;
	logic [2:0]  cycles;
	logic [15:0] skip_pc;
	logic [15:0] br_pc;
	logic [7:0]  bit_mask;

	assign accept = start && (state_q == ST_IDLE);
	assign io_ok = (instr.io_addr <= `IO_BIT_LAST); // [RL20]
	assign bit_mask = 8'h01 << instr.bit_sel;

	// Bit under test comes from register or I/O operand
	always_comb
	begin
		sel_bit = instr.rd_val[instr.bit_sel];
		if (instr.op == OP_SKIP_IO_BIT_CLEAR || instr.op == OP_SKIP_IO_BIT_SET)
			sel_bit = instr.io_rdata[instr.bit_sel];
	end

	// Skip or branch condition per operation
	always_comb
	begin
		cond = 1'b0;
		is_skip = 1'b0;
		is_branch = 1'b1;
		unique case (instr.op)
			OP_COMPARE_SKIP_EQUAL:     cond = (instr.rd_val == instr.rr_val); // [RL2]
			OP_SKIP_REG_BIT_CLEAR:     cond = !sel_bit;                       // [RL4]
			OP_SKIP_REG_BIT_SET:       cond = sel_bit;                        // [RL5]
			OP_SKIP_IO_BIT_CLEAR:      cond = !sel_bit && io_ok;              // [RL6]
			OP_SKIP_IO_BIT_SET:        cond = sel_bit && io_ok;               // [RL6]
			OP_BRANCH_FLAG_SET:        cond = status_flags_register_in[instr.bit_sel];         // [RL7]
			OP_BRANCH_FLAG_CLEAR:      cond = !status_flags_register_in[instr.bit_sel];        // [RL7]
			OP_BRANCH_SAME_HIGHER,
			OP_BRANCH_CARRY_CLEAR:     cond = !status_flags_register_in[`FLAG_C];              // [RL8]
			OP_BRANCH_LOWER,
			OP_BRANCH_CARRY_SET:       cond = status_flags_register_in[`FLAG_C];               // [RL8]
			OP_BRANCH_SIGNED_GE:       cond = !(status_flags_register_in[`FLAG_N] ^ status_flags_register_in[`FLAG_V]); // [RL9]
			OP_BRANCH_SIGNED_LT:       cond = status_flags_register_in[`FLAG_N] ^ status_flags_register_in[`FLAG_V];    // [RL10]
			OP_BRANCH_HALFCARRY_SET:   cond = status_flags_register_in[`FLAG_H];               // [RL11]
			OP_BRANCH_HALFCARRY_CLEAR: cond = !status_flags_register_in[`FLAG_H];              // [RL11]
			OP_BRANCH_BITCOPY_SET:     cond = status_flags_register_in[`FLAG_T];               // [RL12]
			OP_BRANCH_BITCOPY_CLEAR:   cond = !status_flags_register_in[`FLAG_T];              // [RL12]
			OP_BRANCH_OVERFLOW_SET:    cond = status_flags_register_in[`FLAG_V];               // [RL13]
			OP_BRANCH_OVERFLOW_CLEAR:  cond = !status_flags_register_in[`FLAG_V];              // [RL13]
			OP_BRANCH_IRQ_ENABLED:     cond = status_flags_register_in[`FLAG_I];               // [RL14]
			OP_BRANCH_IRQ_DISABLED:    cond = !status_flags_register_in[`FLAG_I];              // [RL14]
			default:                   is_branch = 1'b0;
		endcase
		if (instr.op inside {OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
				OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET})
		begin
			is_skip = 1'b1;
			is_branch = 1'b0;
		end
	end

	// Relative target and skip target
	assign br_pc = instr.pc + {{9{instr.offset[6]}}, instr.offset} + `PC_STEP; // [RL7]
	assign skip_pc = instr.pc + (instr.next_two_word ? `SKIP_TWO : `SKIP_ONE); // [RL2]

	// Compare: difference discarded, only flags kept
	always_comb
	begin
		diff = {1'b0, instr.rd_val} - {1'b0, instr.rr_val};
		if (instr.op == OP_COMPARE_REGS_CARRY)
			diff = diff - {8'h00, status_flags_register_in[`FLAG_C]};
		cmp_flags = status_flags_register_in;
		cmp_flags[`FLAG_C] = diff[8]; // [RL3]
		cmp_flags[`FLAG_N] = diff[7];
		cmp_flags[`FLAG_V] = (instr.rd_val[7] & ~instr.rr_val[7] & ~diff[7])
			| (~instr.rd_val[7] & instr.rr_val[7] & diff[7]);
		cmp_flags[`FLAG_H] = (~instr.rd_val[3] & instr.rr_val[3])
			| (instr.rr_val[3] & diff[3]) | (diff[3] & ~instr.rd_val[3]);
		cmp_flags[`FLAG_Z] = (diff[7:0] == 8'h00);
		// Carry compare keeps zero only if it was already set
		if (instr.op == OP_COMPARE_REGS_CARRY)
			cmp_flags[`FLAG_Z] = (diff[7:0] == 8'h00) && status_flags_register_in[`FLAG_Z];
		cmp_flags[`FLAG_S] = cmp_flags[`FLAG_N] ^ cmp_flags[`FLAG_V];
	end

	// Shifts and rotate through carry
	always_comb
	begin
		shres = {instr.rd_val[6:0], 1'b0};              // [RL19]
		sh_c = instr.rd_val[7];
		if (instr.op == OP_SHIFT_RIGHT_LOGICAL)
		begin
			shres = {1'b0, instr.rd_val[7:1]};          // [RL19]
			sh_c = instr.rd_val[0];
		end
		else if (instr.op == OP_ROTATE_LEFT_CARRY)
			shres = {instr.rd_val[6:0], status_flags_register_in[`FLAG_C]}; // [RL17]
		sh_flags = status_flags_register_in;
		sh_flags[`FLAG_C] = sh_c;
		sh_flags[`FLAG_Z] = (shres == 8'h00);
		sh_flags[`FLAG_N] = shres[7];
		sh_flags[`FLAG_V] = shres[7] ^ sh_c;
		sh_flags[`FLAG_S] = sh_flags[`FLAG_N] ^ sh_flags[`FLAG_V];
	end

	// Cycle count of the offered instruction
	always_comb
	begin
		cycles = `CYC_ONE;
		if (instr.op == OP_POINTER_CALL)
			cycles = `CYC_CALL;                           // [RL1]
		else if (instr.op == OP_SUB_RETURN || instr.op == OP_IRQ_RETURN)
			cycles = `CYC_RETURN;                         // [RL18]
		// A refused address must finish at once, with no PC load
		else if ((instr.op == OP_SET_IO_BIT || instr.op == OP_CLEAR_IO_BIT) && io_ok)
			cycles = `CYC_IO_BIT;                         // [RL15] [RL16] [RL20]
		else if (is_skip && cond)
			cycles = instr.next_two_word ? `CYC_CALL : `CYC_IO_BIT; // [RL2]
		else if (is_branch && cond)
			cycles = `CYC_IO_BIT;                         // [RL7]
	end

	// ********************
	// Sequencer
	// ********************
	// Counts down the extra cycles; new offers are ignored meanwhile
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 3'h0;
			busy_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
					if (accept && cycles != `CYC_ONE)
					begin
						state_q <= ST_WAIT;
						cnt_q <= cycles - `CYC_ONE;
						busy_q <= 1'b1;
					end
				ST_WAIT:
				begin
					cnt_q <= cnt_q - 3'h1;
					if (cnt_q == `CYC_ONE)
					begin
						state_q <= ST_IDLE;
						busy_q <= 1'b0;
					end
				end
			endcase
		end
	end

	// Pending effects published on the last cycle
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pend_pc_q <= 1'b0;
			pend_ret_q <= 1'b0;
			pend_io_q <= 1'b0;
			pend_irq_q <= 1'b0;
		end
		else if (accept)
		begin
			pend_pc_q <= cycles != `CYC_ONE && !pend_io_next();
			pend_ret_q <= instr.op == OP_SUB_RETURN || instr.op == OP_IRQ_RETURN;
			pend_irq_q <= instr.op == OP_IRQ_RETURN;                // [RL18]
			pend_io_q <= pend_io_next();
		end
	end

	function automatic logic pend_io_next();
		pend_io_next = (instr.op == OP_SET_IO_BIT || instr.op == OP_CLEAR_IO_BIT) && io_ok;
	endfunction : pend_io_next

	// ********************
	// Outputs
	// ********************
	// Data words are set on acceptance and held, returns reload pc_next_q at the end; push_q and pop_q pulse on acceptance, other strobes on completion
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			done_q <= 1'b0;
			pc_load_q <= 1'b0;
			pc_next_q <= 16'h0000;
			status_flags_register_we_q <= 1'b0;
			status_flags_register_out_q <= 8'h00;
			res_we_q <= 1'b0;
			res_q <= 8'h00;
			io_we_q <= 1'b0;
			io_addr_q <= 6'h00;
			io_mask_q <= 8'h00;
			io_wdata_q <= 8'h00;
			push_q <= 1'b0;
			push_data_q <= 16'h0000;
			pop_q <= 1'b0;
			bad_io_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			pc_load_q <= 1'b0;
			status_flags_register_we_q <= 1'b0;
			res_we_q <= 1'b0;
			io_we_q <= 1'b0;
			push_q <= 1'b0;
			pop_q <= 1'b0;
			bad_io_q <= 1'b0;
			if (accept)
			begin
				pc_next_q <= is_skip ? skip_pc : br_pc;
				status_flags_register_out_q <= status_flags_register_in;
				io_addr_q <= instr.io_addr;
				io_mask_q <= bit_mask;                               // [RL21]
				io_wdata_q <= (instr.op == OP_SET_IO_BIT) ? bit_mask : 8'h00; // [RL15] [RL16]
				bad_io_q <= !io_ok && (instr.op inside {OP_SET_IO_BIT, OP_CLEAR_IO_BIT,
					OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET});       // [RL20]
				if (instr.op == OP_POINTER_CALL)
				begin
					pc_next_q <= instr.z_ptr;                        // [RL1]
					push_q <= 1'b1;
					push_data_q <= instr.pc + `PC_STEP;
				end
				if (instr.op == OP_SUB_RETURN || instr.op == OP_IRQ_RETURN)
					pop_q <= 1'b1;                                   // [RL18]
				if (instr.op == OP_IRQ_RETURN)
					status_flags_register_out_q[`FLAG_I] <= 1'b1;                     // [RL18]
				if (instr.op inside {OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY,
					OP_COMPARE_IMMEDIATE})
				begin
					status_flags_register_out_q <= cmp_flags;                         // [RL3]
					status_flags_register_we_q <= 1'b1;
					done_q <= 1'b1;
				end
				else if (instr.op inside {OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
					OP_ROTATE_LEFT_CARRY})
				begin
					status_flags_register_out_q <= sh_flags;                          // [RL17] [RL19]
					status_flags_register_we_q <= 1'b1;
					res_q <= shres;
					res_we_q <= 1'b1;
					done_q <= 1'b1;
				end
				else if (cycles == `CYC_ONE)
					done_q <= 1'b1;
			end
			else if (state_q == ST_WAIT && cnt_q == `CYC_ONE)
			begin
				done_q <= 1'b1;
				pc_load_q <= pend_pc_q;
				io_we_q <= pend_io_q;
				if (pend_ret_q)
				begin
					pc_next_q <= pop_data;                           // [RL18]
					status_flags_register_we_q <= pend_irq_q;                         // [RL18]
				end
			end
		end
	end

endmodule : branch_skip_bit_unit

// file: hw/flow_unit_defs.svh
// Constants for the program-flow, skip, bit and shift execution unit
// Notes on behaviour
// RL1: Pointer call: jump to pointer, push return, 3 cycles
// RL2: Equal registers skip next; 1/2/3 cycles, flags kept
// RL3: Compares discard result, update Z N V C H
// RL4: Register bit zero skips next instruction
// RL5: Register bit one skips next instruction
// RL6: I/O bit clear or set skips next
// RL7: Flag branch: taken adds offset plus one, 1/2
// RL8: Carry zero: same-higher, carry-clear; one: lower, carry-set
// RL9: Signed greater-equal taken when N xor V zero
// RL10: Signed less-than taken when N xor V one
// RL11: Half-carry branches follow half-carry flag
// RL12: Bit-copy branches follow bit-copy flag
// RL13: Overflow branches follow overflow flag, flags kept
// RL14: Interrupt branches follow global interrupt enable
// RL15: Set I/O bit in two cycles
// RL16: Clear I/O bit in two cycles
// RL17: Rotate left through carry, flags, one cycle
// RL18: Returns pop PC in four; interrupt return sets enable
// RL19: Logical shifts fill zero, update flags, one cycle
// RL20: I/O bit operations only at addresses 0x00-0x1f
// RL21: I/O bit set or clear touches only that bit
`ifndef FLOW_UNIT_DEFS_SVH
`define FLOW_UNIT_DEFS_SVH

// ********************
// Status flag positions
// ********************
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// ********************
// Cycle counts and distances
// ********************
`define CYC_ONE     3'h1
`define CYC_IO_BIT  3'h2
`define CYC_CALL    3'h3
`define CYC_RETURN  3'h4
`define PC_STEP     16'h0001
`define SKIP_ONE    16'h0002
`define SKIP_TWO    16'h0003
`define IO_BIT_LAST 6'h1f

`endif

// file: hw/flow_unit_pkg.sv
// Types shared by the program-flow execution unit
package flow_unit_pkg;

	// Operations handed over by the decoder
	typedef enum logic [5:0] {
		OP_NOP, OP_POINTER_CALL, OP_SUB_RETURN, OP_IRQ_RETURN,
		OP_COMPARE_SKIP_EQUAL, OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE,
		OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
		OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER,
		OP_BRANCH_CARRY_CLEAR, OP_BRANCH_CARRY_SET, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
		OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_BITCOPY_SET,
		OP_BRANCH_BITCOPY_CLEAR, OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
		OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED, OP_SET_IO_BIT, OP_CLEAR_IO_BIT,
		OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY
	} op_t;

	// One decoded instruction with its operand values
	typedef struct packed {
		op_t         op;            // Operation
		logic [7:0]  rd_val;        // First working register value
		logic [7:0]  rr_val;        // Second register value or immediate
		logic [2:0]  bit_sel;       // Bit b, or flag s for flag branches
		logic [6:0]  offset;        // Signed branch offset k
		logic [5:0]  io_addr;       // I/O register address P
		logic [7:0]  io_rdata;      // Current value of I/O register P
		logic        next_two_word; // Following instruction is two words
		logic [15:0] pc;            // Address of this instruction
		logic [15:0] z_ptr;         // 16-bit pointer register pair
	} instr_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} state_t;

endpackage : flow_unit_pkg

// file: verification/branch_skip_bit_unit_assertions.sv
// Concurrent checks on the ports of the program-flow execution unit
`timescale 1ns/1ps

module branch_skip_bit_unit_assertions
	import flow_unit_pkg::*;
(
	input wire logic        clk,        // Core clock
	input wire logic        srst,       // Sync reset
	input wire logic        start,      // Offer
	input wire instr_t      instr,      // Instruction
	input wire logic [7:0]  status_flags_register_in,    // Flags in
	input wire logic        busy_q,     // Busy
	input wire logic        done_q,     // Done pulse
	input wire logic        pc_load_q,  // PC load
	input wire logic [15:0] pc_next_q,  // PC target
	input wire logic        status_flags_register_we_q,  // Flag write
	input wire logic [7:0]  status_flags_register_out_q, // Flags out
	input wire logic        res_we_q,   // Result write
	input wire logic [7:0]  res_q,      // Result
	input wire logic        io_we_q,    // I/O write
	input wire logic [5:0]  io_addr_q,  // I/O address
	input wire logic [7:0]  io_mask_q,  // I/O mask
	input wire logic [7:0]  io_wdata_q, // I/O data
	input wire logic        pop_q,      // Pop
	input wire logic        bad_io_q    // Bad address
);
	// ********************
	// Helpers and checks
	// ********************
	// Expected values worked out at the accept edge
	wire        acc     = start && !busy_q;
	wire        eq      = instr.rd_val == instr.rr_val;
	wire [15:0] tgt     = instr.pc + {{9{instr.offset[6]}}, instr.offset} + 16'h0001;
	wire [15:0] pc_skip = instr.pc + 16'h0002;
	wire [8:0]  rot_exp = {instr.rd_val, status_flags_register_in[0]};
	wire        io_op   = instr.op inside {OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
		OP_SET_IO_BIT, OP_CLEAR_IO_BIT};

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_call_three_cycles: assert property (acc && instr.op == OP_POINTER_CALL |=> !done_q ##1
		!done_q ##1 (done_q && pc_load_q && pc_next_q == $past(instr.z_ptr, 3)))
		else $error("pointer call timing or target wrong");
	a_return_four_cycles: assert property (acc && instr.op inside {OP_SUB_RETURN, OP_IRQ_RETURN}
		|=> pop_q ##0 (!done_q)[*3] ##1 (done_q && pc_load_q)) else $error("return timing wrong");
	a_irq_return_enable: assert property (acc && instr.op == OP_IRQ_RETURN |-> ##4
		(status_flags_register_we_q && status_flags_register_out_q[7])) else $error("interrupt return left enable clear");
	a_compare_zero_flag: assert property (acc && instr.op == OP_COMPARE_REGS |=> done_q
		&& status_flags_register_we_q && status_flags_register_out_q[1] == $past(eq)) else $error("compare zero flag wrong");
	a_skip_equal_one: assert property (acc && instr.op == OP_COMPARE_SKIP_EQUAL && eq
		&& !instr.next_two_word |=> !done_q ##1 (done_q && pc_load_q
		&& pc_next_q == $past(pc_skip, 2))) else $error("equal skip wrong");
	a_io_range_refused: assert property (acc && io_op && instr.io_addr > 6'h1f |=>
		bad_io_q && done_q && !pc_load_q && !io_we_q) else $error("high I/O address used");
	a_io_single_bit: assert property (io_we_q |-> $onehot(io_mask_q)
		&& io_addr_q <= 6'h1f) else $error("I/O write not one low-address bit");
	a_set_io_two: assert property (acc && instr.op == OP_SET_IO_BIT && instr.io_addr <= 6'h1f
		|=> !done_q ##1 (done_q && io_we_q && (io_wdata_q & io_mask_q) == io_mask_q))
		else $error("set I/O bit wrong");
	a_branch_flag_taken: assert property (acc && instr.op == OP_BRANCH_FLAG_SET
		&& status_flags_register_in[instr.bit_sel] |=> !done_q ##1 (done_q && pc_load_q
		&& pc_next_q == $past(tgt, 2))) else $error("flag branch target wrong");
	a_rotate_carry_in: assert property (acc && instr.op == OP_ROTATE_LEFT_CARRY |=> done_q
		&& res_we_q && {status_flags_register_out_q[0], res_q} == $past(rot_exp)) else $error("rotate wrong");

	// Main scenarios reached
	c_pointer_call: cover property (acc && instr.op == OP_POINTER_CALL);
	c_io_write: cover property (io_we_q);
	c_bad_io: cover property (bad_io_q);
endmodule : branch_skip_bit_unit_assertions

bind branch_skip_bit_unit branch_skip_bit_unit_assertions u_chk (.clk, .srst, .start, .instr,
	.status_flags_register_in, .busy_q, .done_q, .pc_load_q, .pc_next_q, .status_flags_register_we_q, .status_flags_register_out_q, .res_we_q,
	.res_q, .io_we_q, .io_addr_q, .io_mask_q, .io_wdata_q, .pop_q, .bad_io_q);

// file: verification/branch_skip_bit_unit_tb_top.sv
// Self-checking bench for the program-flow execution unit
`timescale 1ns/1ps

module branch_skip_bit_unit_tb_top;
	import flow_unit_pkg::*;

	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        start = 1'b0;
	instr_t      instr = '0;
	logic [7:0]  status_flags_register_in = 8'h00;
	logic [15:0] pop_data = 16'h0000;
	logic [79:0] raw;
	logic        busy_q, done_q, pc_load_q, status_flags_register_we_q, res_we_q, io_we_q, push_q, pop_q, bad_io_q;
	logic [15:0] pc_next_q, push_data_q;
	logic [7:0]  status_flags_register_out_q, res_q, io_mask_q, io_wdata_q;
	logic [5:0]  io_addr_q;
	logic [15:0] rnd = 16'h1db7;
	int          miscompares = 0;
	int          n_compared = 0;

	branch_skip_bit_unit dut (.clk, .srst, .start, .instr, .status_flags_register_in, .pop_data, .busy_q,
		.done_q, .pc_load_q, .pc_next_q, .status_flags_register_we_q, .status_flags_register_out_q, .res_we_q, .res_q, .io_we_q,
		.io_addr_q, .io_mask_q, .io_wdata_q, .push_q, .push_data_q, .pop_q, .bad_io_q);

	// ********************
	// Clock, helpers and model
	// ********************
	// Free-running 100 MHz core clock
	always #5 clk = ~clk;

	// Galois-free shift register, seeded so runs repeat
	function automatic logic [15:0] draw();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd;
	endfunction : draw

	// Compare of any value, zero-extended to a word
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h want %h op %s", $time, got, exp, instr.op.name());
		end
	endtask : chk_word

	// Compare of a one-cycle strobe
	task automatic chk_flag(input logic got, input logic exp);
		chk_word({15'h0000, got}, {15'h0000, exp});
	endtask : chk_flag

	// Verdict, reached from the main sequence or the watchdog
	task automatic end_sim();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// Model one instruction, then follow it to done and compare
	task automatic run_one();
		logic [2:0]  ncy, n, idx;
		logic        ld, swe, rwe, iwe, psh, pp, bad, tk, br, sg, want, c, v;
		logic [15:0] pcn;
		logic [7:0]  f, r, a, b, mask, wd;
		{ld, swe, rwe, iwe, psh, pp, tk, br, sg, want, idx} = '0;
		{ncy, pcn, f, r, a, b} = {3'h1, 16'h0000, status_flags_register_in, 8'h00, instr.rd_val, instr.rr_val};
		bad = instr.io_addr > 6'h1f && instr.op inside {OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
			OP_SET_IO_BIT, OP_CLEAR_IO_BIT};
		mask = 8'h01 << instr.bit_sel;
		wd = (instr.op == OP_SET_IO_BIT) ? mask : 8'h00;
		case (instr.op)
			OP_POINTER_CALL: {ncy, ld, pcn, psh} = {3'h3, 1'b1, instr.z_ptr, 1'b1};
			OP_SUB_RETURN, OP_IRQ_RETURN: {ncy, ld, pcn, pp} = {3'h4, 1'b1, pop_data, 1'b1};
			OP_COMPARE_SKIP_EQUAL: tk = (a == b);
			OP_SKIP_REG_BIT_CLEAR: tk = !a[instr.bit_sel];
			OP_SKIP_REG_BIT_SET: tk = a[instr.bit_sel];
			OP_SKIP_IO_BIT_CLEAR: tk = !instr.io_rdata[instr.bit_sel] && !bad;
			OP_SKIP_IO_BIT_SET: tk = instr.io_rdata[instr.bit_sel] && !bad;
			OP_SET_IO_BIT, OP_CLEAR_IO_BIT: {ncy, iwe} = bad ? {3'h1, 1'b0} : {3'h2, 1'b1};
			OP_BRANCH_FLAG_SET: {br, idx, want} = {1'b1, instr.bit_sel, 1'b1};
			OP_BRANCH_FLAG_CLEAR: {br, idx, want} = {1'b1, instr.bit_sel, 1'b0};
			OP_BRANCH_SAME_HIGHER, OP_BRANCH_CARRY_CLEAR: {br, idx, want} = {1'b1, 3'h0, 1'b0};
			OP_BRANCH_LOWER, OP_BRANCH_CARRY_SET: {br, idx, want} = {1'b1, 3'h0, 1'b1};
			OP_BRANCH_SIGNED_GE: {br, sg, want} = {1'b1, 1'b1, 1'b0};
			OP_BRANCH_SIGNED_LT: {br, sg, want} = {1'b1, 1'b1, 1'b1};
			OP_BRANCH_HALFCARRY_SET: {br, idx, want} = {1'b1, 3'h5, 1'b1};
			OP_BRANCH_HALFCARRY_CLEAR: {br, idx, want} = {1'b1, 3'h5, 1'b0};
			OP_BRANCH_BITCOPY_SET: {br, idx, want} = {1'b1, 3'h6, 1'b1};
			OP_BRANCH_BITCOPY_CLEAR: {br, idx, want} = {1'b1, 3'h6, 1'b0};
			OP_BRANCH_OVERFLOW_SET: {br, idx, want} = {1'b1, 3'h3, 1'b1};
			OP_BRANCH_OVERFLOW_CLEAR: {br, idx, want} = {1'b1, 3'h3, 1'b0};
			OP_BRANCH_IRQ_ENABLED: {br, idx, want} = {1'b1, 3'h7, 1'b1};
			OP_BRANCH_IRQ_DISABLED: {br, idx, want} = {1'b1, 3'h7, 1'b0};
			default: ;
		endcase
		if (br)
			tk = ((sg ? status_flags_register_in[2] ^ status_flags_register_in[3] : status_flags_register_in[idx]) == want);
		if (tk && br)
			{ncy, ld, pcn} = {3'h2, 1'b1, instr.pc + {{9{instr.offset[6]}}, instr.offset} + 16'h0001};
		else if (tk)
			{ncy, ld, pcn} = instr.next_two_word ? {3'h3, 1'b1, instr.pc + 16'h0003}
				: {3'h2, 1'b1, instr.pc + 16'h0002};
		if (instr.op == OP_IRQ_RETURN)
			{swe, f[7]} = 2'h3;
		// Difference is thrown away, only the flags matter
		if (instr.op inside {OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE})
		begin
			r = a - b - ((instr.op == OP_COMPARE_REGS_CARRY) ? {7'h00, status_flags_register_in[0]} : 8'h00);
			c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
			v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
			f[5:0] = {(~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]), r[7] ^ v, v, r[7],
				r == 8'h00 && (instr.op != OP_COMPARE_REGS_CARRY || status_flags_register_in[1]), c};
			swe = 1'b1;
		end
		if (instr.op inside {OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY})
		begin
			{c, r} = (instr.op == OP_SHIFT_RIGHT_LOGICAL) ? {a[0], 1'b0, a[7:1]}
				: {a, instr.op == OP_ROTATE_LEFT_CARRY && status_flags_register_in[0]};
			f[4:0] = {c, r[7] ^ c, r[7], r == 8'h00, c};
			{swe, rwe} = 2'h3;
		end
		@(posedge clk);
		#1 start = 1'b0;
		n = 3'h1;
		chk_flag(push_q, psh);
		chk_word(push_data_q & {16{psh}}, (instr.pc + 16'h0001) & {16{psh}});
		chk_flag(pop_q, pp);
		chk_flag(busy_q, ncy != 3'h1);
		// Bounded wait for the completion pulse
		while (done_q !== 1'b1 && n < 3'h6)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk_word({13'h0000, n}, {13'h0000, ncy});
		chk_flag(busy_q, 1'b0);
		chk_flag(pc_load_q, ld);
		if (ld)
			chk_word(pc_next_q, pcn);
		chk_flag(status_flags_register_we_q, swe);
		if (swe)
			chk_word({8'h00, status_flags_register_out_q}, {8'h00, f});
		chk_flag(res_we_q, rwe);
		if (rwe)
			chk_word({8'h00, res_q}, {8'h00, r});
		chk_flag(io_we_q, iwe);
		if (iwe)
			chk_word({io_mask_q, io_wdata_q & io_mask_q}, {mask, wd});
		if (iwe)
			chk_word({10'h000, io_addr_q}, {10'h000, instr.io_addr});
		chk_flag(bad_io_q, bad);
	endtask : run_one

	// Reset, then every operation with random operands and flags
	initial
	begin
		repeat (6) @(posedge clk);
		#1 srst = 1'b0;
		chk_flag(busy_q | done_q | pc_load_q | io_we_q, 1'b0);
		for (int k = 0; k < 10; k++)
			for (int o = 0; o <= OP_ROTATE_LEFT_CARRY; o++)
			begin
				@(posedge clk);
				#1 raw = {draw(), draw(), draw(), draw(), draw()};
				pop_data = draw();
				instr = instr_t'(raw[78:0]);
				instr.op = op_t'(o);
				status_flags_register_in = pop_data[15:8];
				start = 1'b1;
				run_one();
			end
		end_sim();
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		#100000;
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end
endmodule : branch_skip_bit_unit_tb_top
